// >>> design/tdmcp_pkg.sv
package tdmcp_pkg;
  // serial frame shape
  localparam int SLOT_BITS = 16;
  localparam logic [3:0] LAST_BIT = 4'hF;
  localparam logic [5:0] LAST_SLOT_ONE = 6'h1F;
  localparam logic [5:0] LAST_SLOT_TWO = 6'h3F;
  localparam logic [5:0] SLOT_HALF = 6'h20;
  localparam logic [5:0] OWN_SLOTS_SPLIT = 6'h03;
  localparam logic [5:0] OWN_SLOTS_SHARED = 6'h06;
  localparam logic [5:0] RX_SLOTS = 6'h03;

  // master bit clock from the core clock
  localparam int CORE_CLK_HZ = 100_000_000;
  localparam int BCLK_A_HZ = 12_288_000;
  localparam int BCLK_B_HZ = 11_289_600;
  localparam int BCLK_A_RAW = CORE_CLK_HZ / (2 * BCLK_A_HZ);
  localparam int BCLK_B_RAW = CORE_CLK_HZ / (2 * BCLK_B_HZ);
  localparam logic [3:0] BCLK_A_HALF =
    (BCLK_A_RAW < 1) ? 4'h1 : 4'(BCLK_A_RAW);
  localparam logic [3:0] BCLK_B_HALF =
    (BCLK_B_RAW < 1) ? 4'h1 : 4'(BCLK_B_RAW);

  // register map, byte addresses
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_INPUT = 8'h04;
  localparam logic [7:0] REG_MIX = 8'h08;
  localparam logic [7:0] REG_CAPTURE = 8'h0C;
  localparam logic [7:0] REG_RX_CTRL = 8'h10;
  localparam logic [7:0] REG_RX_PLAY = 8'h14;
  localparam logic [7:0] REG_STATUS = 8'h18;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic mono;
    logic [1:0] ext_ctl;
    logic clk_tristate;
    logic xtal_sel;
    logic frame_rate;
    logic layout;
  } tdmcp_ctrl_t;

  typedef struct packed {
    logic [1:0] source;
    logic [3:0] gain_r;
    logic [3:0] gain_l;
  } tdmcp_input_t;

  // level 0 is +12 dB, each step -1.5 dB down to 31
  typedef struct packed {
    logic mute;
    logic [4:0] level;
  } tdmcp_mix_ch_t;

  typedef struct packed {
    tdmcp_mix_ch_t aux2_r;
    tdmcp_mix_ch_t aux2_l;
    tdmcp_mix_ch_t aux1_r;
    tdmcp_mix_ch_t aux1_l;
  } tdmcp_mix_t;

  typedef struct packed {
    logic analog_en;
    logic mix_en;
    logic mono;
    tdmcp_input_t input_cfg;
    tdmcp_mix_t mix;
  } tdmcp_analog_t;

  localparam tdmcp_ctrl_t CTRL_RST = 7'h00;
  localparam tdmcp_input_t INPUT_RST = 10'h000;
  localparam tdmcp_mix_t MIX_RST = 24'h820820;
  localparam logic [31:0] CAPTURE_RST = 32'h00000000;
  localparam logic [15:0] WORD_RST = 16'h0000;
endpackage : tdmcp_pkg

// >>> design/tdmcp_sync.sv
`timescale 1ns/100ps
module tdmcp_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // levels
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  // first stage feeds only the second
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= async_i;
      sync_ff <= meta_ff;
    end
  end

  assign sync_o = sync_ff;
endmodule : tdmcp_sync

// >>> design/tdmcp_shreg.sv
`timescale 1ns/100ps
module tdmcp_shreg #(
  parameter int W = 16
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // control
  input wire logic load_i,
  input wire logic shift_i,
  input wire logic [W-1:0] data_i,
  input wire logic bit_i,
  // state
  output logic [W-1:0] word_o,
  output logic msb_o
);
  logic [W-1:0] word_ff;

  // load wins over shift, msb leaves first
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      word_ff <= '0;
    end else if (load_i) begin
      word_ff <= data_i;
    end else if (shift_i) begin
      word_ff <= {word_ff[W-2:0], bit_i};
    end
  end

  assign word_o = word_ff;
  assign msb_o = word_ff[W-1];
endmodule : tdmcp_shreg

// >>> design/tdmcp_port.sv
// Local design decisions: the address map and register access over AXI4-Lite.
`timescale 1ns/100ps
// Operation
// R1 - power-down input low clears every control register like reset
// R2 - power-down also switches off reference and all analog circuits
// R3 - master-select high: device drives bit clock and frame sync
// R4 - master-select low: bit clock and frame sync come from the bus
// R5 - system makes exactly one codec master; slaves only in chains
// R6 - slot-pass output high during lsb of device's last owned slot
// R7 - slot-pass input claims next 3 or 6 slots, then slot-pass out
// R8 - board holds slot-pass input low on master or single codec
// R9 - crystal output tristated when slave or tristate bit set
// R10 - buffered crystal output follows the selected crystal
// R11 - external control outputs mirror their register bits
// R12 - frame of 32 slots of 16 bits each; code runs 64 slots between frame syncs when frame-rate select is 0
// R13 - per-channel input gain 0 to 22.5 dB in 1.5 dB steps
// R14 - capture source: line 1, line 2, aux 1 or post-mix
// R15 - global stereo or mono; mono copies left to both channels
// R16 - per-channel aux mix level +12 to -34.5 dB or mute
// R17 - aux mix path runs without playback data
// R18 - master bit clock runs continuously at crystal-set rate; code toggles it every 4 core clocks with either crystal
// R19 - frame-rate select 0: two samples per frame; 1: one
// R20 - every serial word is 16 bits, msb first
// R21 - shared wire: receive three words, then transmit three words
// R22 - slots counted from frame sync; output driven only in own slots
module tdmcp_port
  import tdmcp_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // axi4-lite write
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // straps and power
  input wire logic power_down_n_i,
  input wire logic master_select_i,
  // slot chain
  input wire logic slot_pass_in_i,
  output logic slot_pass_out_o,
  // serial bus
  input wire logic bit_clock_i,
  output logic bit_clock_o,
  output logic bit_clock_oe_o,
  input wire logic frame_sync_i,
  output logic frame_sync_o,
  output logic frame_sync_oe_o,
  input wire logic serial_in_line_i,
  output logic serial_out_line_o,
  output logic serial_out_oe_o,
  // crystals
  input wire logic crystal_a_i,
  input wire logic crystal_b_i,
  output logic buffered_crystal_out_o,
  output logic buffered_crystal_oe_o,
  // analog and external control
  output logic [1:0] external_control_outs_o,
  output tdmcp_analog_t analog_o
);
  // pin synchronisers
  logic [7:0] pin_s;
  logic pd_n_s, master_s, pass_s, bclk_s, fs_s, sdi_s, xa_s, xb_s;

  tdmcp_sync #(.W(8)) u_sync (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .async_i({power_down_n_i, master_select_i, slot_pass_in_i,
              bit_clock_i, frame_sync_i, serial_in_line_i,
              crystal_a_i, crystal_b_i}),
    .sync_o(pin_s)
  );
  assign {pd_n_s, master_s, pass_s, bclk_s, fs_s, sdi_s, xa_s, xb_s} =
    pin_s;

  // reset state held in flops until the synced pin says otherwise
  wire pd = ~pd_n_s;

  // control registers
  tdmcp_ctrl_t ctrl_ff;
  tdmcp_input_t input_ff;
  tdmcp_mix_t mix_ff;
  logic [31:0] capture_ff;
  logic [15:0] rx_ctrl_ff, rx_left_ff, rx_right_ff;

  // axi handshake state
  logic aw_rdy_ff, w_rdy_ff, ar_rdy_ff;
  logic aw_hold_ff, w_hold_ff, bvalid_ff, rvalid_ff;
  logic [7:0] aw_addr_ff;
  logic [31:0] w_data_ff;
  logic [3:0] w_strb_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [31:0] rdata_ff;

  wire aw_take = s_axi_awvalid_i & aw_rdy_ff;
  wire w_take = s_axi_wvalid_i & w_rdy_ff;
  wire ar_take = s_axi_arvalid_i & ar_rdy_ff;
  wire do_write = aw_hold_ff & w_hold_ff & ~bvalid_ff;
  wire nxt_aw_hold = (aw_hold_ff | aw_take) & ~do_write;
  wire nxt_w_hold = (w_hold_ff | w_take) & ~do_write;
  wire nxt_bvalid = do_write | (bvalid_ff & ~s_axi_bready_i);
  wire nxt_rvalid = ar_take | (rvalid_ff & ~s_axi_rready_i);

  // write decode
  wire wr_ctrl = do_write & (aw_addr_ff == REG_CTRL);
  wire wr_input = do_write & (aw_addr_ff == REG_INPUT);
  wire wr_mix = do_write & (aw_addr_ff == REG_MIX);
  wire wr_capture = do_write & (aw_addr_ff == REG_CAPTURE);
  wire wr_ro = (aw_addr_ff == REG_RX_CTRL) |
               (aw_addr_ff == REG_RX_PLAY) | (aw_addr_ff == REG_STATUS);
  wire wr_hit = wr_ctrl | wr_input | wr_mix | wr_capture | wr_ro;

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  wire [31:0] ctrl_w = merge({25'h0000000, ctrl_ff}, w_data_ff,
                             w_strb_ff);
  wire [31:0] input_w = merge({22'h000000, input_ff}, w_data_ff,
                              w_strb_ff);
  wire [31:0] mix_w = merge({8'h00, mix_ff}, w_data_ff, w_strb_ff);
  wire [31:0] capture_w = merge(capture_ff, w_data_ff, w_strb_ff);

  // serial position and ownership state
  logic bclk_gen_ff, bclk_d_ff, fs_gen_ff, fs_lat_ff;
  logic [3:0] div_ff, bit_ff;
  logic [5:0] slot_ff, base_ff;
  logic own_ok_ff, owned_ff, rx_en_ff, rx_store_ff;
  logic [1:0] rx_idx_ff, rx_wr_idx_ff;

  // read decode and status
  wire [31:0] status_word = {22'h000000, pd, master_s, slot_ff,
                             owned_ff, own_ok_ff};
  wire [31:0] rd_word =
    (s_axi_araddr_i == REG_CTRL) ? {25'h0000000, ctrl_ff} :
    (s_axi_araddr_i == REG_INPUT) ? {22'h000000, input_ff} :
    (s_axi_araddr_i == REG_MIX) ? {8'h00, mix_ff} :
    (s_axi_araddr_i == REG_CAPTURE) ? capture_ff :
    (s_axi_araddr_i == REG_RX_CTRL) ? {16'h0000, rx_ctrl_ff} :
    (s_axi_araddr_i == REG_RX_PLAY) ? {rx_right_ff, rx_left_ff} :
    (s_axi_araddr_i == REG_STATUS) ? status_word : 32'h00000000;
  wire rd_hit = (s_axi_araddr_i[7:2] <= REG_STATUS[7:2]) &
                (s_axi_araddr_i[1:0] == 2'h0);

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aw_hold_ff <= 1'b0;
      w_hold_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      aw_rdy_ff <= 1'b0;
      w_rdy_ff <= 1'b0;
      ar_rdy_ff <= 1'b0;
    end else begin
      aw_hold_ff <= nxt_aw_hold;
      w_hold_ff <= nxt_w_hold;
      bvalid_ff <= nxt_bvalid;
      rvalid_ff <= nxt_rvalid;
      aw_rdy_ff <= ~nxt_aw_hold & ~nxt_bvalid;
      w_rdy_ff <= ~nxt_w_hold & ~nxt_bvalid;
      ar_rdy_ff <= ~nxt_rvalid;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aw_addr_ff <= 8'h00;
      w_data_ff <= 32'h00000000;
      w_strb_ff <= 4'h0;
      bresp_ff <= RESP_OKAY;
      rresp_ff <= RESP_OKAY;
      rdata_ff <= 32'h00000000;
    end else begin
      if (aw_take) aw_addr_ff <= s_axi_awaddr_i;
      if (w_take) w_data_ff <= s_axi_wdata_i;
      if (w_take) w_strb_ff <= s_axi_wstrb_i;
      if (do_write) bresp_ff <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      if (ar_take) rdata_ff <= rd_hit ? rd_word : 32'h00000000;
      if (ar_take) rresp_ff <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // software registers; power-down clears them like reset
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_ff <= CTRL_RST;
      input_ff <= INPUT_RST;
      mix_ff <= MIX_RST;
      capture_ff <= CAPTURE_RST;
    end else if (pd) begin // R1
      ctrl_ff <= CTRL_RST;
      input_ff <= INPUT_RST;
      mix_ff <= MIX_RST;
      capture_ff <= CAPTURE_RST;
    end else begin
      if (wr_ctrl) ctrl_ff <= ctrl_w[6:0];
      if (wr_input) input_ff <= input_w[9:0]; // R13 R14
      if (wr_mix) mix_ff <= mix_w[23:0]; // R16
      if (wr_capture) capture_ff <= capture_w;
    end
  end

  // bit clock: master divides core clock, slave samples the pin
  wire [3:0] half = ctrl_ff.xtal_sel ? BCLK_B_HALF : BCLK_A_HALF;
  wire div_tick = (div_ff == half - 4'h1);
  wire bclk_now = master_s ? bclk_gen_ff : bclk_s; // R3 R4
  wire bit_rise = bclk_now & ~bclk_d_ff;
  wire bit_fall = ~bclk_now & bclk_d_ff;
  wire fs_now = master_s ? fs_gen_ff : fs_s;

  // rate only approximates the crystal figure at this core clock
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_ff <= 4'h0;
      bclk_gen_ff <= 1'b0;
      bclk_d_ff <= 1'b0;
    end else begin
      div_ff <= div_tick ? 4'h0 : div_ff + 4'h1;
      if (div_tick & master_s) bclk_gen_ff <= ~bclk_gen_ff; // R18
      bclk_d_ff <= bclk_now;
    end
  end

  // next position on each rising bit edge
  wire [5:0] slot_last = ctrl_ff.frame_rate ? LAST_SLOT_ONE
                                             : LAST_SLOT_TWO; // R19
  wire slot_wrap = (bit_ff == LAST_BIT);
  wire [3:0] nxt_bit = fs_lat_ff ? 4'h0 : bit_ff + 4'h1; // R20
  wire [5:0] nxt_slot =
    fs_lat_ff ? 6'h00 :
    !slot_wrap ? slot_ff :
    (slot_ff == slot_last) ? 6'h00 : slot_ff + 6'h01; // R12 R22
  wire [5:0] base_now = master_s ? (nxt_slot & SLOT_HALF) : base_ff;
  wire ok_now = master_s | (own_ok_ff & ~fs_lat_ff);
  wire [5:0] rel = nxt_slot - base_now;
  wire [5:0] own_n = ctrl_ff.layout ? OWN_SLOTS_SPLIT
                                    : OWN_SLOTS_SHARED; // R7
  wire owned_nxt = ok_now & (rel < own_n) & ~pd;
  wire shared = ~ctrl_ff.layout;
  wire rx_nxt = owned_nxt & (~shared | (rel < RX_SLOTS)); // R21
  wire tx_nxt = owned_nxt & (~shared | (rel >= RX_SLOTS));
  wire [5:0] tx_rel = shared ? rel - RX_SLOTS : rel;
  wire pass_nxt = owned_nxt & (rel == own_n - 6'h01) &
                  (nxt_bit == LAST_BIT); // R6
  wire fs_nxt = master_s & (nxt_slot == slot_last) &
                (nxt_bit == LAST_BIT);

  // transmit words; mono repeats the left capture word
  wire [15:0] cap_l = capture_ff[15:0];
  wire [15:0] cap_r = ctrl_ff.mono ? cap_l : capture_ff[31:16]; // R15
  wire [15:0] stat_tx = {1'b0, ctrl_ff, rx_ctrl_ff[7:0]};
  wire [15:0] tx_word = (tx_rel[1:0] == 2'h0) ? stat_tx :
                        (tx_rel[1:0] == 2'h1) ? cap_l : cap_r;
  wire tx_load = bit_rise & tx_nxt & (nxt_bit == 4'h0);
  wire tx_shift = bit_rise & ~tx_load;
  wire rx_shift = bit_fall & rx_en_ff;
  wire [15:0] rx_word;
  logic oe_ff, pass_out_ff;

  tdmcp_shreg #(.W(SLOT_BITS)) u_tx (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .load_i(tx_load),
    .shift_i(tx_shift),
    .data_i(tx_word),
    .bit_i(1'b0),
    .word_o(),
    .msb_o(serial_out_line_o)
  );

  tdmcp_shreg #(.W(SLOT_BITS)) u_rx (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .load_i(1'b0),
    .shift_i(rx_shift),
    .data_i(WORD_RST),
    .bit_i(sdi_s),
    .word_o(rx_word),
    .msb_o()
  );

  // position, ownership and pin enables move on the rising bit edge
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bit_ff <= LAST_BIT;
      slot_ff <= 6'h00;
      owned_ff <= 1'b0;
      rx_en_ff <= 1'b0;
      rx_idx_ff <= 2'h0;
      oe_ff <= 1'b0;
      pass_out_ff <= 1'b0;
      fs_gen_ff <= 1'b0;
    end else if (bit_rise) begin
      bit_ff <= nxt_bit;
      slot_ff <= nxt_slot;
      owned_ff <= owned_nxt;
      rx_en_ff <= rx_nxt;
      rx_idx_ff <= rel[1:0];
      oe_ff <= tx_nxt; // R22
      pass_out_ff <= pass_nxt; // R6 R7
      fs_gen_ff <= fs_nxt; // R3
    end
  end

  // frame sync and chain input are taken on the falling bit edge
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fs_lat_ff <= 1'b0;
      own_ok_ff <= 1'b0;
      base_ff <= 6'h00;
      rx_store_ff <= 1'b0;
      rx_wr_idx_ff <= 2'h0;
    end else begin
      if (bit_fall) fs_lat_ff <= fs_now; // R22
      else if (bit_rise) fs_lat_ff <= 1'b0;
      if (pd | (bit_rise & fs_lat_ff)) begin
        own_ok_ff <= 1'b0;
      // master ignores the chain input, held low by the board
      end else if (bit_fall & pass_s & ~master_s & ~owned_ff) begin // R8
        own_ok_ff <= 1'b1; // R7
        base_ff <= slot_ff + 6'h01;
      end
      rx_store_ff <= rx_shift & (bit_ff == LAST_BIT);
      if (rx_shift) rx_wr_idx_ff <= rx_idx_ff;
    end
  end

  // received words land one cycle after their last bit
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_ctrl_ff <= WORD_RST;
      rx_left_ff <= WORD_RST;
      rx_right_ff <= WORD_RST;
    end else if (pd) begin // R1
      rx_ctrl_ff <= WORD_RST;
      rx_left_ff <= WORD_RST;
      rx_right_ff <= WORD_RST;
    end else if (rx_store_ff) begin // R20 R21
      if (rx_wr_idx_ff == 2'h0) rx_ctrl_ff <= rx_word;
      if (rx_wr_idx_ff == 2'h1) rx_left_ff <= rx_word;
      if (rx_wr_idx_ff == 2'h2) rx_right_ff <= rx_word;
    end
  end

  // pins, crystal buffer and analog settings, all registered
  logic bclk_oe_ff, xtal_ff, xtal_oe_ff;
  logic [1:0] ext_ff;
  tdmcp_analog_t analog_ff;

  // crystal is resampled at core rate, so edges carry jitter
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bclk_oe_ff <= 1'b0;
      xtal_ff <= 1'b0;
      xtal_oe_ff <= 1'b0;
      ext_ff <= 2'h0;
      analog_ff <= '0;
    end else begin
      bclk_oe_ff <= master_s & ~pd; // R3 R4
      xtal_ff <= ctrl_ff.xtal_sel ? xb_s : xa_s; // R10
      xtal_oe_ff <= master_s & ~ctrl_ff.clk_tristate; // R9
      ext_ff <= ctrl_ff.ext_ctl; // R11
      analog_ff.analog_en <= ~pd; // R2
      analog_ff.mix_en <= ~pd; // R17
      analog_ff.mono <= ctrl_ff.mono; // R15
      analog_ff.input_cfg <= input_ff; // R13 R14
      analog_ff.mix <= mix_ff; // R16
    end
  end

  assign s_axi_awready_o = aw_rdy_ff;
  assign s_axi_wready_o = w_rdy_ff;
  assign s_axi_bresp_o = bresp_ff;
  assign s_axi_bvalid_o = bvalid_ff;
  assign s_axi_arready_o = ar_rdy_ff;
  assign s_axi_rdata_o = rdata_ff;
  assign s_axi_rresp_o = rresp_ff;
  assign s_axi_rvalid_o = rvalid_ff;
  assign slot_pass_out_o = pass_out_ff;
  assign bit_clock_o = bclk_gen_ff;
  assign bit_clock_oe_o = bclk_oe_ff;
  assign frame_sync_o = fs_gen_ff;
  assign frame_sync_oe_o = bclk_oe_ff;
  assign serial_out_oe_o = oe_ff;
  assign buffered_crystal_out_o = xtal_ff;
  assign buffered_crystal_oe_o = xtal_oe_ff;
  assign external_control_outs_o = ext_ff;
  assign analog_o = analog_ff;
endmodule : tdmcp_port

// >>> sim/tdmcp_port_props.sv
`timescale 1ns/100ps
module tdmcp_port_chk
  import tdmcp_pkg::*;
(
  // clock, reset and straps
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic power_down_n_i,
  input wire logic master_select_i,
  // watched outputs
  input wire logic bit_clock_o,
  input wire logic bit_clock_oe_o,
  input wire logic frame_sync_oe_o,
  input wire logic buffered_crystal_oe_o,
  input wire logic s_axi_bvalid_o,
  input wire logic [1:0] external_control_outs_o,
  input wire tdmcp_analog_t analog_o
);
  default clocking @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  // five cycles leaves room for the pin synchronisers
  sequence slave_s;
    !master_select_i [*5];
  endsequence
  sequence down_s;
    !power_down_n_i [*5];
  endsequence
  xtal_off_a: assert property (slave_s |-> !buffered_crystal_oe_o)
    else $error("crystal out driven while slave");
  slave_pins_a: assert property (slave_s |-> !bit_clock_oe_o)
    else $error("bit clock driven while slave");
  master_pins_a: assert property (
    (master_select_i && power_down_n_i) [*6] |-> bit_clock_oe_o)
    else $error("bit clock not driven as master");
  sync_oe_a: assert property (slave_s |-> !frame_sync_oe_o)
    else $error("frame sync driven while slave");
  pd_analog_a: assert property (
    down_s |-> !analog_o.analog_en && !analog_o.mix_en)
    else $error("analog still on in power-down");
  pd_regs_a: assert property (
    down_s |-> external_control_outs_o == 2'h0 && analog_o.mix == MIX_RST)
    else $error("registers not cleared in power-down");
  clk_runs_a: assert property (@(posedge core_clk_i)
    disable iff (!rst_n_i || !power_down_n_i || !master_select_i)
    bit_clock_oe_o && $rose(bit_clock_o) |-> ##[1:8] $fell(bit_clock_o))
    else $error("master bit clock stalled");
  ext_mirror_a: assert property (
    $changed(external_control_outs_o) |->
      !power_down_n_i || $past(s_axi_bvalid_o))
    else $error("control outputs moved without a write");
endmodule : tdmcp_port_chk
bind tdmcp_port tdmcp_port_chk chk_u (.core_clk_i, .rst_n_i,
  .power_down_n_i, .master_select_i, .bit_clock_o, .bit_clock_oe_o,
  .frame_sync_oe_o, .buffered_crystal_oe_o, .s_axi_bvalid_o,
  .external_control_outs_o, .analog_o);

// >>> sim/tdmcp_far.sv
`timescale 1ns/100ps
module tdmcp_far (
  // frame control
  input wire logic run_i,
  input wire logic [47:0] words_i,
  // bus side
  output logic bclk_o,
  output logic fsync_o,
  output logic sdata_o,
  output logic pass_o,
  output logic [8:0] bit_o
);
  logic [8:0] nb;
  assign nb = bit_o + 9'h001;
  initial begin
    bclk_o = 1'b0;
    fsync_o = 1'b0;
    sdata_o = 1'b0;
    pass_o = 1'b0;
    bit_o = 9'h1FF;
  end
  // sole master, 160 ns period; clock stands low between frames
  always #80 if (run_i || bclk_o) bclk_o = ~bclk_o;
  always @(posedge bclk_o) begin
    bit_o <= nb;
    fsync_o <= nb == 9'h1FF;
    // upstream handover after slot 4, silent while stopped
    pass_o <= nb == 9'h04F;
    // slots 5 to 7 carry words msb first, elsewhere a moving level
    if (nb >= 9'h050 && nb < 9'h080) begin
      sdata_o <= words_i[6'(9'h07F - nb)];
    end else begin
      sdata_o <= ~sdata_o;
    end
  end
endmodule : tdmcp_far

// >>> sim/tdm_codec_port_slot_chain_test.sv
`timescale 1ns/100ps
module tdm_codec_port_slot_chain_test;
  import tdmcp_pkg::*;
  localparam logic [47:0] PLAY = 48'hC35A_1234_ABCD;
  localparam logic [31:0] CAP = 32'h9E01_6B37;
  logic core_clk_i = 1'b0, rst_n_i = 1'b0, far_run = 1'b0;
  logic [7:0] s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
  logic [31:0] s_axi_wdata_i = 32'h0, s_axi_rdata_o;
  logic [3:0] s_axi_wstrb_i = 4'hF;
  logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0;
  logic s_axi_bready_i = 1'b0, s_axi_arvalid_i = 1'b0;
  logic s_axi_rready_i = 1'b0, power_down_n_i = 1'b1;
  logic master_select_i = 1'b0, crystal_a_i = 1'b1, crystal_b_i = 1'b0;
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o;
  logic s_axi_rvalid_o, slot_pass_out_o, bit_clock_o, bit_clock_oe_o;
  logic frame_sync_o, frame_sync_oe_o, serial_out_line_o, serial_out_oe_o;
  logic buffered_crystal_out_o, buffered_crystal_oe_o;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o, external_control_outs_o, resp;
  tdmcp_analog_t analog_o;
  wire bit_clock_i, frame_sync_i, serial_in_line_i, slot_pass_in_i;
  logic [8:0] far_bit;
  logic oe_b [512];
  logic dat_b [512];
  int pass_at, cyc = 0, num_errors = 0, checked = 0;

  tdmcp_port dut_u (.core_clk_i, .rst_n_i, .s_axi_awaddr_i,
    .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i,
    .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o,
    .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o,
    .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i,
    .power_down_n_i, .master_select_i, .slot_pass_in_i, .slot_pass_out_o,
    .bit_clock_i, .bit_clock_o, .bit_clock_oe_o, .frame_sync_i,
    .frame_sync_o, .frame_sync_oe_o, .serial_in_line_i, .serial_out_line_o,
    .serial_out_oe_o, .crystal_a_i, .crystal_b_i, .buffered_crystal_out_o,
    .buffered_crystal_oe_o, .external_control_outs_o, .analog_o);
  tdmcp_far far_u (.run_i(far_run), .words_i(PLAY), .bclk_o(bit_clock_i),
    .fsync_o(frame_sync_i), .sdata_o(serial_in_line_i),
    .pass_o(slot_pass_in_i), .bit_o(far_bit));

  always #5 core_clk_i = ~core_clk_i;
  always @(negedge bit_clock_i) begin
    oe_b[far_bit] = serial_out_oe_o;
    dat_b[far_bit] = serial_out_line_o;
    if (slot_pass_out_o) pass_at = far_bit;
  end
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    // well above the roughly 60000 cycles the sequence needs
    if (cyc == 90000) begin
      $display("BAD %0t timeout", $time);
      num_errors++;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    do begin
      @(posedge core_clk_i);
      if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
      if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
    end while (!s_axi_bvalid_o);
    s_axi_bready_i <= 1'b0;
    resp = s_axi_bresp_o;
    // mirrored outputs move one edge after the response
    @(posedge core_clk_i);
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    @(posedge core_clk_i);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    do begin
      @(posedge core_clk_i);
      if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
    end while (!s_axi_rvalid_o);
    s_axi_rready_i <= 1'b0;
    resp = s_axi_rresp_o;
    chk(s_axi_rdata_o, e);
  endtask : rc
  // first edge starts the count, the second edge ends it and gives the period
  task automatic per(input logic s, input int e);
    int t0;
    @(posedge (s ? frame_sync_o : bit_clock_o));
    @(posedge core_clk_i);
    t0 = cyc;
    @(posedge (s ? frame_sync_o : bit_clock_o));
    @(posedge core_clk_i);
    chk(32'(cyc - t0), 32'(e));
  endtask : per
  // the frame after the first sync is judged; the one before may be partial
  task automatic frame(input logic [6:0] c);
    int t, n, k;
    logic [15:0] w [3];
    t = c[0] ? 5 : 8;
    n = 0;
    k = 0;
    wr(REG_CTRL, 32'(c));
    wr(REG_CAPTURE, CAP);
    far_run <= 1'b1;
    @(posedge frame_sync_i);
    foreach (oe_b[i]) oe_b[i] = 1'b0;
    pass_at = 0;
    @(posedge frame_sync_i);
    far_run <= 1'b0;
    foreach (oe_b[i]) n += oe_b[i];
    for (int i = 0; i < 48; i++) begin
      w[i / 16][15 - i % 16] = dat_b[t * 16 + i];
      k += oe_b[t * 16 + i];
    end
    chk(32'(pass_at), 32'(t * 16 + 47));
    chk(32'(k), 32'h30);
    chk(32'(n - k), 32'h0);
    chk(32'(w[1]), 32'(CAP[15:0]));
    chk(32'(w[2]), c[6] ? 32'(CAP[15:0]) : 32'(CAP[31:16]));
    rc(REG_RX_CTRL, 32'(PLAY[47:32]));
    rc(REG_RX_PLAY, {PLAY[15:0], PLAY[31:16]});
  endtask : frame

  initial begin
    repeat (20) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    repeat (5) @(posedge core_clk_i);
    rc(REG_CTRL, 32'h0);
    rc(REG_MIX, 32'(MIX_RST));
    rc(8'h1C, 32'h0);
    chk(32'(resp), 32'(RESP_SLVERR));
    for (int i = 0; i < 4; i++) begin
      wr(REG_CTRL, 32'(i << 4));
      chk(32'(external_control_outs_o), 32'(i));
      wr(REG_INPUT, 32'((i << 8) | 'h0F0));
      chk(32'(analog_o.input_cfg), 32'((i << 8) | 'h0F0));
    end
    wr(REG_MIX, 32'h00FE07C0);
    chk(32'(analog_o.mix), 32'h00FE07C0);
    chk(32'(analog_o.mix_en), 32'h1);
    wr(REG_CTRL, 32'h40);
    chk(32'(analog_o.mono), 32'h1);
    power_down_n_i <= 1'b0;
    repeat (6) @(posedge core_clk_i);
    chk(32'({analog_o.analog_en, analog_o.mix_en}), 32'h0);
    power_down_n_i <= 1'b1;
    repeat (5) @(posedge core_clk_i);
    rc(REG_MIX, 32'(MIX_RST));
    rc(REG_CTRL, 32'h0);
    frame(7'h00);
    frame(7'h41);
    master_select_i <= 1'b1;
    wr(REG_CTRL, 32'h0);
    repeat (6) @(posedge core_clk_i);
    chk(32'({bit_clock_oe_o, buffered_crystal_oe_o}), 32'h3);
    chk(32'(buffered_crystal_out_o), 32'(crystal_a_i));
    per(1'b0, 2 * BCLK_A_HALF);
    per(1'b1, 64 * SLOT_BITS * 2 * BCLK_A_HALF);
    wr(REG_CTRL, 32'h6);
    per(1'b0, 2 * BCLK_B_HALF);
    chk(32'(buffered_crystal_out_o), 32'(crystal_b_i));
    per(1'b1, 32 * SLOT_BITS * 2 * BCLK_B_HALF);
    wr(REG_CTRL, 32'hE);
    chk(32'(buffered_crystal_oe_o), 32'h0);
    master_select_i <= 1'b0;
    repeat (6) @(posedge core_clk_i);
    chk(32'(bit_clock_oe_o), 32'h0);
    summarize();
  end
endmodule : tdm_codec_port_slot_chain_test
